// ===== logic/bsfc_core.sv
// buck start-up, soft-start, switching frequency and shutdown control
// Contract
// - conversion starts only with bus above lockout and enable pin high
// - lockout threshold defaults to one volt, rewritable via on/off registers
// - digitized input voltage is only reported, never used for control
// - pre-bias start keeps low-side off until first high-side pulse
// - low-side on-time starts at one eighth, grows per eighth every sixteen cycles
// - ramp starts after enable, bus ok and configuration load
// - analog mode ramps reference zero to half volt in two ms
// - digital mode delays ramp by zero to 127 ms set by software
// - digital mode rise time is one to 127 ms set by software
// - overcurrent and overvoltage protection stay active during start-up
// - analog frequency latched once at init from pin reading
// - analog frequency is one of sixteen values 306 to 1500 kHz
// - digital frequency defaults 607 kHz, programmable 250 to 1500 kHz
// - analog mode sync clock present at init, later lost, disables conversion
// - sync appearing after init toggles between external and free-running frequency
// - frequency moves gradually toward new target either way
// - ramp slope follows applied frequency for constant amplitude
// - enable low turns both drivers off at once
// - digital mode may allow shutdown by software operation bit
// - configuration copied to working registers before start-up proceeds
// - floating address pin at init selects analog mode and freezes configuration
`timescale 1ns/1ps
`default_nettype none
module bsfc_core #(
  parameter int unsigned MS_CYC = bsfc_pkg::MS_CYCLES
) (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  // pins and comparators (asynchronous)
  input  wire logic        enable_forced_ccm_pin,
  input  wire logic        addr_pin_floating,
  input  wire logic        freq_set_sync_pin,
  input  wire logic [3:0]  timing_resistor_code,
  input  wire logic [9:0]  power_input_bus_mv,
  input  wire logic [9:0]  vin_adc_code,
  input  wire logic        ocp_trip,
  input  wire logic        ovp_trip,
  // power stage
  output bsfc_pkg::bsfc_drive_t drive,
  output logic             analog_mode
);
  typedef struct packed {
    logic [1:0]  en_s, sync_s, flt_s, ocp_s, ovp_s;
    logic [3:0]  rt_s;
    logic [9:0]  pv_s;
    logic [9:0]  vadc_s;
    bsfc_pkg::bsfc_state_t st;
    logic [4:0]  load_cnt;
    logic        analog;
    logic        sync_at_init;
    logic [6:0]  ton_delay, ton_rise;
    logic [10:0] freq_prog, freq_free, freq_act;
    logic [9:0]  vin_on, vin_off;
    logic        bus_ok, op_on, op_allow;
    logic [31:0] tcnt;
    logic [6:0]  ms_cnt;
    logic [9:0]  vref;
    logic [31:0] acc;
    logic        hs_seen;
    logic [3:0]  pb_step;
    logic [4:0]  pb_cyc;
    logic [7:0]  pwm_cnt;
    logic        sync_prev, sync_det;
    logic [9:0]  sync_idle;
    logic [9:0]  fstep;
    logic [10:0] ext_khz;
    logic [15:0] edge_gap;
    logic        fault;
    logic [31:0] rdata;
    logic        rdy;
  } bsfc_st_t;

  bsfc_st_t q, d;

  // sixteen pin-selected frequencies
  function automatic logic [10:0] rt_freq(input logic [3:0] c);
    case (c)
      4'h0: rt_freq = 11'd306;  4'h1: rt_freq = 11'd356;  4'h2: rt_freq = 11'd400;  4'h3: rt_freq = 11'd444;
      4'h4: rt_freq = 11'd500;  4'h5: rt_freq = 11'd550;  4'h6: rt_freq = 11'd600;  4'h7: rt_freq = 11'd706;
      4'h8: rt_freq = 11'd750;  4'h9: rt_freq = 11'd800;  4'hA: rt_freq = 11'd923;  4'hB: rt_freq = 11'd1000;
      4'hC: rt_freq = 11'd1091; 4'hD: rt_freq = 11'd1200; 4'hE: rt_freq = 11'd1333; default: rt_freq = 11'd1500;
    endcase
  endfunction

  function automatic logic [10:0] clamp_f(input logic [10:0] f);
    clamp_f = (f < bsfc_pkg::FREQ_MIN) ? bsfc_pkg::FREQ_MIN : (f > bsfc_pkg::FREQ_MAX) ? bsfc_pkg::FREQ_MAX : f;
  endfunction

  logic        wr, rd, en_ok, run_ok, sync_edge;
  logic [10:0] f_target;
  logic [6:0]  rise_ms;
  logic [31:0] rise_cyc;
  logic [31:0] ext32;

  always_comb begin
    d          = q;
    wr         = psel && penable && pwrite;
    rd         = psel && !penable && !pwrite;
    // input synchronisers; only stage 1 is read by logic
    d.en_s     = {q.en_s[0], enable_forced_ccm_pin};
    d.sync_s   = {q.sync_s[0], freq_set_sync_pin};
    d.flt_s    = {q.flt_s[0], addr_pin_floating};
    d.ocp_s    = {q.ocp_s[0], ocp_trip};
    d.ovp_s    = {q.ovp_s[0], ovp_trip};
    d.rt_s     = timing_resistor_code;
    d.pv_s     = power_input_bus_mv;
    d.vadc_s   = vin_adc_code;
    sync_edge  = q.sync_s[1] && !q.sync_prev;
    d.sync_prev = q.sync_s[1];
    // bus lockout hysteresis from programmed thresholds only
    if (q.pv_s >= q.vin_on)
      d.bus_ok = 1'b1;
    else if (q.pv_s < q.vin_off)
      d.bus_ok = 1'b0;
    en_ok      = q.en_s[1] && q.bus_ok;
    run_ok     = en_ok && !q.fault && (q.analog || !q.op_allow || q.op_on);
    rise_ms    = q.analog ? 7'(bsfc_pkg::SS_ANALOG_MS) : ((q.ton_rise == 7'h00) ? 7'h01 : q.ton_rise);
    rise_cyc   = 32'(rise_ms) * 32'(MS_CYC);

    // sync detection and loss; 32-bit divide so a saturated gap cannot wrap to zero
    ext32 = (32'(bsfc_pkg::CLK_HZ) / 32'd1000) / (32'(q.edge_gap) + 32'h1);
    if (sync_edge) begin
      d.sync_det  = 1'b1;
      d.sync_idle = '0;
      d.edge_gap  = '0;
      if (q.edge_gap != 16'h0000)
        d.ext_khz = (ext32 > 32'(bsfc_pkg::FREQ_MAX)) ? bsfc_pkg::FREQ_MAX : clamp_f(ext32[10:0]);
    end else begin
      d.edge_gap = (q.edge_gap == 16'hFFFF) ? q.edge_gap : q.edge_gap + 16'h0001;
      if (q.sync_idle == 10'(bsfc_pkg::SYNC_LOSS_CYC)) begin
        d.sync_det = 1'b0;
      end else begin
        d.sync_idle = q.sync_idle + 10'h001;
      end
    end

    // gradual frequency slew toward target
    f_target = (q.sync_det && q.st != bsfc_pkg::ST_LOAD) ? q.ext_khz : q.freq_free;
    if (q.fstep == 10'(bsfc_pkg::FSTEP_CYCLES)) begin
      d.fstep = '0;
      if (q.freq_act < f_target)
        d.freq_act = q.freq_act + 11'h001;
      else if (q.freq_act > f_target)
        d.freq_act = q.freq_act - 11'h001;
    end else begin
      d.fstep = q.fstep + 10'h001;
    end
    if (!q.analog)
      d.freq_free = q.freq_prog;

    d.pwm_cnt = q.pwm_cnt + 8'h01;

    case (q.st)
      bsfc_pkg::ST_LOAD: begin
        // copy of nonvolatile defaults, strap and frequency pin reading
        d.load_cnt = q.load_cnt + 5'h01;
        if (q.load_cnt == 5'(bsfc_pkg::LOAD_CYCLES)) begin
          d.analog       = q.flt_s[1];
          d.sync_at_init = q.sync_det;
          d.freq_free    = rt_freq(q.rt_s);
          d.freq_act     = q.flt_s[1] ? rt_freq(q.rt_s) : q.freq_prog;
          d.st           = bsfc_pkg::ST_IDLE;
        end
      end
      bsfc_pkg::ST_IDLE: begin
        d.vref = '0;
        d.hs_seen = 1'b0;
        d.pb_step = 4'h1;
        d.pb_cyc = '0;
        d.tcnt = '0;
        d.ms_cnt = '0;
        d.acc = '0;
        if (run_ok)
          d.st = q.analog ? bsfc_pkg::ST_RAMP : bsfc_pkg::ST_DELAY;
      end
      bsfc_pkg::ST_DELAY: begin
        if (q.ms_cnt >= q.ton_delay) begin
          d.st = bsfc_pkg::ST_RAMP;
          d.tcnt = '0;
        end else if (q.tcnt == 32'(MS_CYC - 1)) begin
          d.tcnt = '0;
          d.ms_cnt = q.ms_cnt + 7'h01;
        end else begin
          d.tcnt = q.tcnt + 32'h1;
        end
      end
      bsfc_pkg::ST_RAMP: begin
        // exact linear ramp: vref = target * t / rise
        d.tcnt = q.tcnt + 32'h1;
        d.acc  = q.acc + 32'(bsfc_pkg::VREF_TARGET);
        if (q.acc + 32'(bsfc_pkg::VREF_TARGET) >= rise_cyc) begin
          d.acc  = q.acc + 32'(bsfc_pkg::VREF_TARGET) - rise_cyc;
          d.vref = q.vref + 10'h001;
        end
        if (q.tcnt + 32'h1 >= rise_cyc) begin
          d.vref = bsfc_pkg::VREF_TARGET;
          d.st   = bsfc_pkg::ST_ON;
        end
      end
      bsfc_pkg::ST_ON: ;
      bsfc_pkg::ST_FAULT: ;
      default: d.st = bsfc_pkg::ST_IDLE;
    endcase

    // pre-bias low-side stepping: first hs pulse, then eighths
    if (q.st == bsfc_pkg::ST_RAMP || q.st == bsfc_pkg::ST_ON) begin
      if (q.pwm_cnt == 8'hFF) begin
        d.hs_seen = 1'b1;
        if (q.hs_seen && q.pb_step != 4'(bsfc_pkg::PB_STEPS)) begin
          if (q.pb_cyc == 5'(bsfc_pkg::PB_STEP_CYCLES - 1)) begin
            d.pb_cyc  = '0;
            d.pb_step = q.pb_step + 4'h1;
          end else begin
            d.pb_cyc = q.pb_cyc + 5'h01;
          end
        end
      end
    end

    // loss of init-time sync in analog mode is a system failure
    if (q.analog && q.sync_at_init && !q.sync_det && q.st != bsfc_pkg::ST_LOAD)
      d.fault = 1'b1;
    // protection active in every state except load and idle, start-up included
    if ((q.ocp_s[1] || q.ovp_s[1]) && q.st != bsfc_pkg::ST_LOAD && q.st != bsfc_pkg::ST_IDLE)
      d.st = bsfc_pkg::ST_IDLE;
    if (!run_ok && q.st != bsfc_pkg::ST_LOAD)
      d.st = bsfc_pkg::ST_IDLE;

    // apb: zero wait states, unmapped reads zero, writes frozen in analog mode
    d.rdy = 1'b0;
    if (rd) begin
      case (paddr)
        bsfc_pkg::A_CTRL:      d.rdata = {30'h0, q.op_allow, q.op_on};
        bsfc_pkg::A_TON_DELAY: d.rdata = {25'h0, q.ton_delay};
        bsfc_pkg::A_TON_RISE:  d.rdata = {25'h0, q.ton_rise};
        bsfc_pkg::A_FREQ:      d.rdata = {21'h0, q.freq_prog};
        bsfc_pkg::A_VIN_ON:    d.rdata = {22'h0, q.vin_on};
        bsfc_pkg::A_VIN_OFF:   d.rdata = {22'h0, q.vin_off};
        bsfc_pkg::A_STATUS:    d.rdata = {24'h0, q.fault, q.sync_det, q.analog, q.bus_ok, 1'b0, q.st};
        bsfc_pkg::A_READ_VIN:  d.rdata = {22'h0, q.vadc_s};
        bsfc_pkg::A_FREQ_ACT:  d.rdata = {21'h0, q.freq_act};
        bsfc_pkg::A_VREF:      d.rdata = {22'h0, q.vref};
        default:               d.rdata = 32'h0000_0000;
      endcase
    end
    if (wr && !q.analog && q.st != bsfc_pkg::ST_LOAD) begin
      case (paddr)
        // clearing a latched fault wins over a fault raised in this same cycle
        bsfc_pkg::A_CTRL:      begin d.op_on = pwdata[0]; d.op_allow = pwdata[1]; d.fault = (pwdata[2] && q.fault) ? 1'b0 : d.fault; end
        bsfc_pkg::A_TON_DELAY: d.ton_delay = pwdata[6:0];
        bsfc_pkg::A_TON_RISE:  d.ton_rise = pwdata[6:0];
        bsfc_pkg::A_FREQ:      d.freq_prog = clamp_f(pwdata[10:0]);
        bsfc_pkg::A_VIN_ON:    d.vin_on = pwdata[9:0];
        bsfc_pkg::A_VIN_OFF:   d.vin_off = pwdata[9:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q           <= '0;
      q.st        <= bsfc_pkg::ST_LOAD;
      q.ton_delay <= bsfc_pkg::TON_DELAY_RST;
      q.ton_rise  <= bsfc_pkg::TON_RISE_RST;
      q.freq_prog <= bsfc_pkg::FREQ_DIG_RST;
      q.freq_free <= bsfc_pkg::FREQ_DIG_RST;
      q.freq_act  <= bsfc_pkg::FREQ_DIG_RST;
      q.vin_on    <= bsfc_pkg::UVLO_RST;
      q.vin_off   <= bsfc_pkg::UVLO_OFF_RST;
      q.ext_khz   <= bsfc_pkg::FREQ_DIG_RST;
      q.pb_step   <= 4'h1;
    end else begin
      q <= d;
    end
  end

  logic on_st;
  assign on_st   = (q.st == bsfc_pkg::ST_RAMP) || (q.st == bsfc_pkg::ST_ON);
  assign pready  = 1'b1;
  assign pslverr = 1'b0;
  assign prdata  = q.rdata;
  assign analog_mode = q.analog;
  // low-side window: pb_step eighths of the period (seven at pb_step 8), after the high-side window
  assign drive.hs_on      = on_st && (q.pwm_cnt[7:5] == 3'h0);
  assign drive.ls_on      = on_st && q.hs_seen && (q.pwm_cnt[7:5] >= 3'(4'h8 - q.pb_step)) && (q.pwm_cnt[7:5] != 3'h0);
  assign drive.vref       = q.vref;
  assign drive.freq_khz   = q.freq_act;
  assign drive.ramp_slope = q.freq_act;
endmodule : bsfc_core
`default_nettype wire

// ===== logic/bsfc_pkg.sv
// package: constants and carrier types for the buck start-up and frequency control block
`default_nettype none
package bsfc_pkg;
  localparam int unsigned CLK_HZ          = 40000000;
  localparam int unsigned MS_CYCLES       = CLK_HZ / 1000;
  localparam int unsigned SS_ANALOG_MS    = 2;
  localparam logic [9:0]  VREF_TARGET     = 10'h1F4;   // 0.5 V in 1 mV codes
  localparam logic [6:0]  TON_DELAY_RST   = 7'h00;
  localparam logic [6:0]  TON_RISE_RST    = 7'h02;
  localparam logic [10:0] FREQ_DIG_RST    = 11'h25F;   // 607 kHz
  localparam logic [10:0] FREQ_MIN        = 11'h0FA;   // 250 kHz
  localparam logic [10:0] FREQ_MAX        = 11'h5DC;   // 1500 kHz
  localparam logic [9:0]  UVLO_RST        = 10'h3E8;   // 1 V in 1 mV codes
  localparam logic [9:0]  UVLO_OFF_RST    = 10'h3E8;
  localparam int unsigned PB_STEP_CYCLES  = 16;
  localparam int unsigned PB_STEPS        = 8;
  localparam int unsigned LOAD_CYCLES     = 16;
  localparam int unsigned SYNC_LOSS_CYC   = 400;       // 10 us without an edge
  localparam int unsigned FSTEP_CYCLES    = 400;       // 10 us between 1 kHz slew steps
  // apb map
  localparam logic [7:0] A_CTRL      = 8'h00;
  localparam logic [7:0] A_TON_DELAY = 8'h04;
  localparam logic [7:0] A_TON_RISE  = 8'h08;
  localparam logic [7:0] A_FREQ      = 8'h0C;
  localparam logic [7:0] A_VIN_ON    = 8'h10;
  localparam logic [7:0] A_VIN_OFF   = 8'h14;
  localparam logic [7:0] A_STATUS    = 8'h18;
  localparam logic [7:0] A_READ_VIN  = 8'h1C;
  localparam logic [7:0] A_FREQ_ACT  = 8'h20;
  localparam logic [7:0] A_VREF      = 8'h24;
  typedef enum logic [2:0] {ST_LOAD, ST_IDLE, ST_DELAY, ST_RAMP, ST_ON, ST_FAULT} bsfc_state_t;
  typedef struct packed {
    logic       hs_on;
    logic       ls_on;
    logic [9:0] vref;
    logic [10:0] freq_khz;
    logic [10:0] ramp_slope;
  } bsfc_drive_t;
endpackage : bsfc_pkg
`default_nettype wire

// ===== sim/bsfc_chk.sv
// checker: port assertions for the start-up and frequency control block
`timescale 1ns/1ps
`default_nettype none
module bsfc_chk #(
  parameter int unsigned MS_CYC = 40
) (
  // clock and reset
  input wire logic                  pclk,
  input wire logic                  presetn,
  // apb handshake
  input wire logic                  psel,
  input wire logic                  penable,
  input wire logic                  pready,
  input wire logic                  pslverr,
  // pins and stage drive
  input wire logic                  enable_forced_ccm_pin,
  input wire bsfc_pkg::bsfc_drive_t drive
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [2:0] en_low_q;
  logic       hs_seen_q;
  // cleared only once all is quiet, so the sync delay on enable cannot fake a fault
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_low_q  <= 3'h7;
      hs_seen_q <= 1'b0;
    end else begin
      en_low_q  <= enable_forced_ccm_pin ? 3'h0 : (en_low_q == 3'h7 ? en_low_q : en_low_q + 3'h1);
      if (!enable_forced_ccm_pin && !drive.hs_on && !drive.ls_on) hs_seen_q <= 1'b0;
      else if (drive.hs_on) hs_seen_q <= 1'b1;
    end
  end
  drv_off_a: assert property (!enable_forced_ccm_pin [*5] |-> !drive.hs_on && !drive.ls_on)
    else $error("driver on with enable low");
  hs_enable_a: assert property ($rose(drive.hs_on) |-> en_low_q < 3'h6)
    else $error("high side started without enable");
  ls_first_a: assert property (drive.ls_on |-> hs_seen_q || drive.hs_on)
    else $error("low side before first high side pulse");
  vref_max_a: assert property (drive.vref <= bsfc_pkg::VREF_TARGET)
    else $error("reference above target");
  freq_range_a: assert property (drive.freq_khz >= bsfc_pkg::FREQ_MIN && drive.freq_khz <= bsfc_pkg::FREQ_MAX)
    else $error("frequency out of range");
  freq_step_a: assert property ($changed(drive.freq_khz) |=> $stable(drive.freq_khz) [*8])
    else $error("frequency jumped");
  slope_track_a: assert property ($changed(drive.freq_khz) |-> ##[0:2] $changed(drive.ramp_slope))
    else $error("ramp slope did not follow frequency");
  apb_answer_a: assert property (psel && penable |-> pready && !pslverr)
    else $error("apb access not answered");
endmodule // bsfc_chk
bind bsfc_core bsfc_chk #(.MS_CYC(MS_CYC)) bsfc_chk_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pready(pready), .pslverr(pslverr), .enable_forced_ccm_pin(enable_forced_ccm_pin),
  .drive(drive));
`default_nettype wire

// ===== sim/bsfc_stage_model.sv
// power stage comparators and sync clock source facing the control block
`timescale 1ns/1ps
`default_nettype none
module bsfc_stage_model (
  // clock and reset
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  // stage side
  input  wire bsfc_pkg::bsfc_drive_t drive,
  input  wire logic [1:0]            trip_req,
  input  wire logic [7:0]            sync_half,
  output logic                       ocp_trip,
  output logic                       ovp_trip,
  output logic                       sync_pin,
  output logic [15:0]                hs_pulses
);
  logic [7:0] cnt_q = 8'h00;
  logic       hs_q;
  // sync is not reset so it can already run while the block loads
  always_ff @(posedge pclk) begin
    cnt_q <= (cnt_q + 8'h01 >= sync_half) ? 8'h00 : cnt_q + 8'h01;
    if (sync_half == 8'h00) sync_pin <= 1'b0;
    else if (cnt_q + 8'h01 >= sync_half) sync_pin <= ~sync_pin;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {ocp_trip, ovp_trip, hs_q} <= 3'h0;
      hs_pulses <= 16'h0000;
    end else begin
      {ovp_trip, ocp_trip} <= trip_req;
      hs_q <= drive.hs_on;
      if (drive.hs_on && !hs_q) hs_pulses <= hs_pulses + 16'h0001;
    end
  end
endmodule // bsfc_stage_model
`default_nettype wire

// ===== sim/tb_bsfc_core.sv
// self-checking bench for the start-up and frequency control block
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin n_tests++; if ((s) !== (e)) begin mismatches++; $display("mismatch %s exp %0h got %0h", n, e, s); end end
module tb_bsfc_core;
  typedef struct {logic w; logic [7:0] a; logic [31:0] d; logic [31:0] e;} bsfc_row_t;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, en = 1'b0, fl = 1'b0;
  logic [7:0]  paddr = 8'h00, sync_half = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, r;
  logic        pready, pslverr, analog_mode, ocp, ovp, sync_pin;
  logic [1:0]  trip = 2'h0;
  logic [3:0]  code = 4'h0;
  logic [9:0]  bus_mv = 10'h000, adc = 10'h155;
  logic [15:0] hs_pulses;
  bsfc_pkg::bsfc_drive_t drive;
  int          mismatches = 0, n_tests = 0, n;
  logic [10:0] af [16] = '{11'h132, 11'h164, 11'h190, 11'h1BC, 11'h1F4, 11'h226, 11'h258, 11'h2C2,
                           11'h2EE, 11'h320, 11'h39B, 11'h3E8, 11'h443, 11'h4B0, 11'h535, 11'h5DC};
  bsfc_row_t   rows [14] = '{
    '{1'b0, bsfc_pkg::A_TON_DELAY, 32'h0, 32'h0},
    '{1'b0, bsfc_pkg::A_TON_RISE, 32'h0, 32'h2},
    '{1'b0, bsfc_pkg::A_FREQ, 32'h0, 32'h25F},
    '{1'b0, bsfc_pkg::A_VIN_ON, 32'h0, 32'h3E8},
    '{1'b0, bsfc_pkg::A_VIN_OFF, 32'h0, 32'h3E8},
    '{1'b1, bsfc_pkg::A_TON_DELAY, 32'h7F, 32'h7F},
    '{1'b1, bsfc_pkg::A_TON_DELAY, 32'h1, 32'h1},
    '{1'b1, bsfc_pkg::A_TON_RISE, 32'h7F, 32'h7F},
    '{1'b1, bsfc_pkg::A_TON_RISE, 32'h1, 32'h1},
    '{1'b1, bsfc_pkg::A_FREQ, 32'hFB, 32'hFB},
    '{1'b1, bsfc_pkg::A_FREQ, 32'h64, 32'hFA},
    '{1'b1, bsfc_pkg::A_FREQ, 32'h7D0, 32'h5DC},
    '{1'b1, bsfc_pkg::A_FREQ, 32'h25F, 32'h25F},
    '{1'b0, 8'h40, 32'h0, 32'h0}};
  bsfc_core #(.MS_CYC(40)) bsfc_core_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .enable_forced_ccm_pin(en), .addr_pin_floating(fl), .freq_set_sync_pin(sync_pin),
    .timing_resistor_code(code), .power_input_bus_mv(bus_mv), .vin_adc_code(adc), .ocp_trip(ocp),
    .ovp_trip(ovp), .drive(drive), .analog_mode(analog_mode));
  bsfc_stage_model bsfc_stage_model_inst (.pclk(pclk), .presetn(presetn), .drive(drive), .trip_req(trip),
    .sync_half(sync_half), .ocp_trip(ocp), .ovp_trip(ovp), .sync_pin(sync_pin), .hs_pulses(hs_pulses));
  always #12.5 pclk = ~pclk;
  task automatic cyc(input int k);
    repeat (k) @(posedge pclk);
    #1;
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk) penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rst(input logic f, input logic [3:0] c);
    @(posedge pclk);
    presetn <= 1'b0;
    fl <= f;
    code <= c;
    en <= 1'b0;
    cyc(20);
    @(posedge pclk) presetn <= 1'b1;
    cyc(30);
  endtask
  // both waits give up after a bound so a stuck design still reaches the verdict
  task automatic wait_vref;
    n = 0;
    while (drive.vref !== bsfc_pkg::VREF_TARGET && n < 2000) begin
      @(posedge pclk);
      #1 n++;
    end
  endtask
  task automatic wait_hs;
    n = 0;
    while (drive.hs_on !== 1'b1 && n < 2000) begin
      @(posedge pclk);
      #1 n++;
    end
    `CHK("hs seen", 1'b1, drive.hs_on)
  endtask
  task automatic done(input string s);
    $display("test %s done", s);
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    cyc(60000);
    mismatches++;
    end_of_test();
  end
  initial begin
    rst(1'b0, 4'h0);
    foreach (rows[i]) begin
      if (rows[i].w) apb(1'b1, rows[i].a, rows[i].d);
      apb(1'b0, rows[i].a, 32'h0);
      `CHK("reg", rows[i].e, r)
    end
    done("registers");
    @(posedge pclk) bus_mv <= 10'h384;
    @(posedge pclk) en <= 1'b1;
    cyc(100);
    `CHK("lockout", 16'h0000, hs_pulses)
    apb(1'b1, bsfc_pkg::A_VIN_ON, 32'h320);
    apb(1'b1, bsfc_pkg::A_VIN_OFF, 32'h320);
    @(posedge pclk) adc <= 10'h2AA;
    wait_vref();
    `CHK("delay rise", 1'b1, n inside {[70:90]})
    wait_hs();
    n = 0;
    while (drive.ls_on !== 1'b1 && n < 600) begin
      @(posedge pclk);
      #1 n++;
    end
    n = 0;
    while (drive.ls_on === 1'b1 && n < 600) begin
      @(posedge pclk);
      #1 n++;
    end
    `CHK("ls eighth", 32'd32, n)
    apb(1'b0, bsfc_pkg::A_READ_VIN, 32'h0);
    `CHK("read vin", 32'h2AA, r)
    @(posedge pclk) trip <= 2'h1;
    cyc(6);
    `CHK("ocp", 12'h000, {drive.hs_on, drive.ls_on, drive.vref})
    @(posedge pclk) trip <= 2'h2;
    cyc(6);
    `CHK("ovp", 12'h000, {drive.hs_on, drive.ls_on, drive.vref})
    @(posedge pclk) trip <= 2'h0;
    wait_hs();
    apb(1'b1, bsfc_pkg::A_CTRL, 32'h2);
    cyc(6);
    `CHK("op off", 2'h0, {drive.hs_on, drive.ls_on})
    apb(1'b1, bsfc_pkg::A_CTRL, 32'h3);
    wait_hs();
    @(posedge pclk) en <= 1'b0;
    cyc(6);
    `CHK("en off", 2'h0, {drive.hs_on, drive.ls_on})
    done("start and shutdown");
    @(posedge pclk) sync_half <= 8'h20;
    cyc(2000);
    `CHK("slew up", 1'b1, drive.freq_khz > 11'h25F && drive.freq_khz < 11'h271)
    cyc(8000);
    `CHK("sync freq", 11'h271, drive.freq_khz)
    @(posedge pclk) sync_half <= 8'h00;
    cyc(2000);
    `CHK("slew down", 1'b1, drive.freq_khz > 11'h25F && drive.freq_khz < 11'h271)
    cyc(8000);
    `CHK("free run", 11'h25F, drive.freq_khz)
    done("sync");
    for (int i = 0; i < 16; i++) begin
      rst(1'b1, i[3:0]);
      `CHK("rt freq", af[i], drive.freq_khz)
    end
    `CHK("analog", 1'b1, analog_mode)
    @(posedge pclk) code <= 4'h0;
    apb(1'b1, bsfc_pkg::A_FREQ, 32'hFB);
    cyc(1000);
    `CHK("rt frozen", 11'h5DC, drive.freq_khz)
    @(posedge pclk) bus_mv <= 10'h3FF;
    @(posedge pclk) en <= 1'b1;
    wait_vref();
    `CHK("analog ramp", 1'b1, n inside {[76:92]})
    // fast sync so an edge is surely seen inside the short load window
    sync_half <= 8'h04;
    rst(1'b1, 4'h4);
    @(posedge pclk) en <= 1'b1;
    wait_hs();
    @(posedge pclk) sync_half <= 8'h00;
    cyc(600);
    apb(1'b0, bsfc_pkg::A_STATUS, 32'h0);
    `CHK("sync lost", 3'h4, {r[7], drive.hs_on, drive.ls_on})
    done("analog");
    end_of_test();
  end
endmodule // tb_bsfc_core
`default_nettype wire
